/* File: verilog/lcp_command_port.sv */
// command and parameter interpreter behind the 8-bit host port
// Behaviour
// - reset pin low clears whole internal state
// - no bytes accepted while reset pin low
// - command on write with select high
// - display switch sets enable and attributes
// - region setup takes up to ten bytes
// - glyph base and cursor shape two bytes
// - direction codes set move direction, no bytes
// - fine shift takes exactly one byte
// - layer compose takes one byte
// - cursor address bytes handled individually
// - memory write streams every following byte
// - memory read streams bytes on reads
// - parameter bytes apply on arrival, except glyph base and region address pairs
// - preempted command keeps remaining registers
// - paired bytes apply together, lone discarded
// - address pitch bytes applied independently
// - select picks command/data and status/data
// - enable-strobe mode read high, write falling
// - separate-strobe mode write rising, read low
// - style input chooses the bus mode
`timescale 1ns/1ns
module lcp_command_port (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        dev_rst_n,
   input  wire logic        bus_style_select,
   input  wire logic        chip_sel_n,
   input  wire logic        register_select,
   input  wire logic        wr_n_rw,
   input  wire logic        rd_n_en,
   input  wire logic [7:0]  db_in,
   output logic      [7:0]  db_out,
   output logic             db_oe,
   output logic [7:0][7:0]  sys_param_q,
   output logic [9:0][7:0]  region_param_q,
   output logic [1:0][7:0]  cursor_shape_q,
   output logic [15:0]      glyph_base_q,
   output logic [7:0]       fine_hshift_q,
   output logic [7:0]       layer_compose_q,
   output logic             display_on_q,
   output logic [7:0]       display_attr_q,
   output logic [1:0]       cursor_dir_q,
   output logic [15:0]      cursor_addr_q,
   output logic             standby_q,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   output logic             mem_we,
   output logic             mem_re,
   input  wire logic [7:0]  mem_rdata
);
   logic [13:0]        pins_s;
   logic               wr_ev;
   logic               wr_rs;
   logic [7:0]         wr_data;
   logic               rd_start;
   logic               rd_end;
   logic               run_q;
   lcp_pkg::lcp_state_t state_q;
   logic [3:0]         idx_q;
   logic [7:0]         pend_q;
   logic               rd_rs_q;
   logic               fetch_q;
   logic [7:0]         rd_byte_q;

   lcp_sync #(
      .W         (14),
      .RESET_VAL (14'h0b00)
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   ({dev_rst_n, bus_style_select, chip_sel_n, register_select, wr_n_rw,
                  rd_n_en, db_in}),
      .stable_q (pins_s)
   );

   lcp_strobe u_strobe (
      .core_clk (core_clk),
      .rst      (rst),
      .style    (pins_s[12]),
      .cs_n     (pins_s[11]),
      .rw_wr_n  (pins_s[9]),
      .rd_n_e   (pins_s[8]),
      .rs       (pins_s[10]),
      .data     (pins_s[7:0]),
      .wr_ev    (wr_ev),
      .wr_rs    (wr_rs),
      .wr_data  (wr_data),
      .rd_start (rd_start),
      .rd_end   (rd_end)
   );

   // next cursor position for a streamed byte; vertical moves use the pitch
   function automatic logic [15:0] lcp_step(input logic [15:0] addr,
                                            input logic [1:0]  dir,
                                            input logic [15:0] pitch);
      logic [15:0] r;
      r = addr;
      unique case (dir)
         lcp_pkg::DIR_RIGHT: r = addr + 16'h0001;
         lcp_pkg::DIR_LEFT:  r = addr - 16'h0001;
         lcp_pkg::DIR_UP:    r = addr - pitch;
         lcp_pkg::DIR_DOWN:  r = addr + pitch;
      endcase
      return r;
   endfunction

   wire        dev_run   = pins_s[13];
   wire        accept_wr = wr_ev & run_q;
   wire        cmd_wr    = accept_wr & wr_rs;
   wire        par_wr    = accept_wr & ~wr_rs;
   wire        accept_rd = rd_end & run_q;
   wire [15:0] pitch     = {sys_param_q[lcp_pkg::PITCH_HIGH_IDX],
                            sys_param_q[lcp_pkg::PITCH_LOW_IDX]};
   wire [15:0] next_csr  = lcp_step(cursor_addr_q, cursor_dir_q, pitch);
   wire [3:0]  idx_inc   = idx_q + 4'd1;
   // region addresses are pairs at 0/1, 3/4, 6/7, 8/9; line counts stand alone
   wire        reg_low   = (idx_q == 4'd0) | (idx_q == 4'd3) | (idx_q == 4'd6) |
                           (idx_q == 4'd8);
   wire        reg_high  = (idx_q == 4'd1) | (idx_q == 4'd4) | (idx_q == 4'd7) |
                           (idx_q == 4'd9);
   wire [7:0]  status    = {1'b0, display_on_q, 5'h00, standby_q};

   lcp_pkg::lcp_state_t cmd_state;
   always_comb begin
      cmd_state = lcp_pkg::LCP_IDLE;
      if (wr_data == lcp_pkg::CMD_SYSTEM_SETUP)       cmd_state = lcp_pkg::LCP_SYS;
      else if (wr_data == lcp_pkg::CMD_REGION_SETUP)  cmd_state = lcp_pkg::LCP_REGION;
      else if (wr_data == lcp_pkg::CMD_CURSOR_SHAPE)  cmd_state = lcp_pkg::LCP_SHAPE;
      else if (wr_data == lcp_pkg::CMD_GLYPH_BASE)    cmd_state = lcp_pkg::LCP_GLYPH;
      else if (wr_data == lcp_pkg::CMD_FINE_HSHIFT)   cmd_state = lcp_pkg::LCP_HSHIFT;
      else if (wr_data == lcp_pkg::CMD_LAYER_COMPOSE) cmd_state = lcp_pkg::LCP_COMPOSE;
      else if (wr_data[7:1] == lcp_pkg::CMD_DISPLAY_SW) cmd_state = lcp_pkg::LCP_DISP;
      else if (wr_data == lcp_pkg::CMD_CURSOR_WRITE)  cmd_state = lcp_pkg::LCP_CSR_WR;
      else if (wr_data == lcp_pkg::CMD_CURSOR_READ)   cmd_state = lcp_pkg::LCP_CSR_RD;
      else if (wr_data == lcp_pkg::CMD_MEMORY_WRITE)  cmd_state = lcp_pkg::LCP_MEM_WR;
      else if (wr_data == lcp_pkg::CMD_MEMORY_READ)   cmd_state = lcp_pkg::LCP_MEM_RD;
   end

   // read byte for high select: cursor bytes in cursor-read mode, else memory
   wire [7:0] data_rd = (state_q == lcp_pkg::LCP_CSR_RD) ?
                        (idx_q[0] ? cursor_addr_q[15:8] : cursor_addr_q[7:0]) :
                        rd_byte_q;
   wire [7:0] rd_sel  = pins_s[10] ? data_rd : status;

   always_ff @(posedge core_clk) begin
      if (rst || !dev_run) begin
         run_q           <= 1'b0;
         state_q         <= lcp_pkg::LCP_IDLE;
         idx_q           <= 4'd0;
         pend_q          <= lcp_pkg::BYTE_RESET;
         sys_param_q     <= '0;
         region_param_q  <= '0;
         cursor_shape_q  <= '0;
         glyph_base_q    <= lcp_pkg::WORD_RESET;
         fine_hshift_q   <= lcp_pkg::BYTE_RESET;
         layer_compose_q <= lcp_pkg::BYTE_RESET;
         display_on_q    <= 1'b0;
         display_attr_q  <= lcp_pkg::BYTE_RESET;
         cursor_dir_q    <= lcp_pkg::DIR_RIGHT;
         cursor_addr_q   <= lcp_pkg::WORD_RESET;
         standby_q       <= 1'b0;
         mem_addr        <= lcp_pkg::WORD_RESET;
         mem_wdata       <= lcp_pkg::BYTE_RESET;
         mem_we          <= 1'b0;
         mem_re          <= 1'b0;
         fetch_q         <= 1'b0;
         rd_byte_q       <= lcp_pkg::BYTE_RESET;
         rd_rs_q         <= 1'b0;
         db_out          <= lcp_pkg::BYTE_RESET;
         db_oe           <= 1'b0;
      end else begin
         // one idle cycle after release hides strobe edges from sync settling
         run_q   <= 1'b1;
         mem_we  <= 1'b0;
         mem_re  <= 1'b0;
         fetch_q <= mem_re;
         if (fetch_q) begin
            rd_byte_q <= mem_rdata;
         end
         if (cmd_wr) begin
            state_q <= cmd_state;
            idx_q   <= 4'd0;
            if (wr_data == lcp_pkg::CMD_STANDBY) begin
               standby_q <= 1'b1;
            end
            if (wr_data == lcp_pkg::CMD_SYSTEM_SETUP) begin
               standby_q <= 1'b0;
            end
            if (wr_data[7:1] == lcp_pkg::CMD_DISPLAY_SW) begin
               display_on_q <= wr_data[0];
            end
            if (wr_data[7:2] == lcp_pkg::CMD_CURSOR_DIR) begin
               cursor_dir_q <= wr_data[1:0];
            end
            if (wr_data == lcp_pkg::CMD_MEMORY_READ) begin
               mem_re   <= 1'b1;
               mem_addr <= cursor_addr_q;
            end
         end else if (par_wr) begin
            unique case (state_q)
               lcp_pkg::LCP_SYS: begin
                  // pitch bytes sit at 6 and 7 and land on their own
                  if (idx_q < lcp_pkg::SYS_PARAM_COUNT) begin
                     sys_param_q[idx_q[2:0]] <= wr_data;
                     idx_q                   <= idx_inc;
                  end
               end
               lcp_pkg::LCP_REGION: begin
                  if (idx_q < lcp_pkg::REGION_PARAM_COUNT) begin
                     idx_q <= idx_inc;
                     if (reg_low) begin
                        pend_q <= wr_data;
                     end else if (reg_high) begin
                        region_param_q[idx_q - 4'd1] <= pend_q;
                        region_param_q[idx_q]        <= wr_data;
                     end else begin
                        region_param_q[idx_q] <= wr_data;
                     end
                  end
               end
               lcp_pkg::LCP_SHAPE: begin
                  if (idx_q < lcp_pkg::SHAPE_PARAM_COUNT) begin
                     cursor_shape_q[idx_q[0]] <= wr_data;
                     idx_q                    <= idx_inc;
                  end
               end
               lcp_pkg::LCP_GLYPH: begin
                  if (idx_q == 4'd0) begin
                     pend_q <= wr_data;
                     idx_q  <= idx_inc;
                  end else if (idx_q == 4'd1) begin
                     glyph_base_q <= {wr_data, pend_q};
                     idx_q        <= idx_inc;
                  end
               end
               lcp_pkg::LCP_HSHIFT: begin
                  if (idx_q == 4'd0) begin
                     fine_hshift_q <= wr_data;
                     idx_q         <= idx_inc;
                  end
               end
               lcp_pkg::LCP_COMPOSE: begin
                  if (idx_q == 4'd0) begin
                     layer_compose_q <= wr_data;
                     idx_q           <= idx_inc;
                  end
               end
               lcp_pkg::LCP_DISP: begin
                  if (idx_q == 4'd0) begin
                     display_attr_q <= wr_data;
                     idx_q          <= idx_inc;
                  end
               end
               lcp_pkg::LCP_CSR_WR: begin
                  if (idx_q == 4'd0) begin
                     cursor_addr_q[7:0] <= wr_data;
                     idx_q              <= idx_inc;
                  end else if (idx_q == 4'd1) begin
                     cursor_addr_q[15:8] <= wr_data;
                     idx_q               <= idx_inc;
                  end
               end
               lcp_pkg::LCP_MEM_WR: begin
                  mem_we        <= 1'b1;
                  mem_addr      <= cursor_addr_q;
                  mem_wdata     <= wr_data;
                  cursor_addr_q <= next_csr;
               end
               lcp_pkg::LCP_IDLE, lcp_pkg::LCP_CSR_RD, lcp_pkg::LCP_MEM_RD: begin
                  idx_q <= idx_q;
               end
            endcase
         end
         if (rd_start && run_q) begin
            db_out  <= rd_sel;
            db_oe   <= 1'b1;
            rd_rs_q <= pins_s[10];
         end else if (rd_end) begin
            db_oe <= 1'b0;
         end
         if (accept_rd && rd_rs_q) begin
            if (state_q == lcp_pkg::LCP_CSR_RD && idx_q < 4'd2) begin
               idx_q <= idx_inc;
            end else if (state_q == lcp_pkg::LCP_MEM_RD) begin
               cursor_addr_q <= next_csr;
               mem_re        <= 1'b1;
               mem_addr      <= next_csr;
            end
         end
      end
   end
endmodule // lcp_command_port

/* File: verilog/lcp_pkg.sv */
// shared codes, field positions, reset values and sizes of the command port
package lcp_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned DEV_PERIOD_NS  = 100;
   localparam int unsigned SYNC_STAGES    = 3;

   localparam logic [7:0] CMD_SYSTEM_SETUP  = 8'h40;
   localparam logic [7:0] CMD_STANDBY       = 8'h53;
   localparam logic [6:0] CMD_DISPLAY_SW    = 7'h2c;   // 0x58/0x59, low bit is enable
   localparam logic [7:0] CMD_REGION_SETUP  = 8'h44;
   localparam logic [7:0] CMD_CURSOR_SHAPE  = 8'h5d;
   localparam logic [7:0] CMD_GLYPH_BASE    = 8'h5c;
   localparam logic [5:0] CMD_CURSOR_DIR    = 6'h13;   // 0x4c..0x4f, low two bits direction
   localparam logic [7:0] CMD_FINE_HSHIFT   = 8'h5a;
   localparam logic [7:0] CMD_LAYER_COMPOSE = 8'h5b;
   localparam logic [7:0] CMD_CURSOR_WRITE  = 8'h46;
   localparam logic [7:0] CMD_CURSOR_READ   = 8'h47;
   localparam logic [7:0] CMD_MEMORY_WRITE  = 8'h42;
   localparam logic [7:0] CMD_MEMORY_READ   = 8'h43;

   localparam logic [3:0] SYS_PARAM_COUNT    = 4'd8;
   localparam logic [3:0] REGION_PARAM_COUNT = 4'd10;
   localparam logic [3:0] SHAPE_PARAM_COUNT  = 4'd2;
   localparam logic [3:0] PITCH_LOW_IDX      = 4'd6;
   localparam logic [3:0] PITCH_HIGH_IDX     = 4'd7;

   localparam logic [1:0] DIR_RIGHT = 2'd0;
   localparam logic [1:0] DIR_LEFT  = 2'd1;
   localparam logic [1:0] DIR_UP    = 2'd2;
   localparam logic [1:0] DIR_DOWN  = 2'd3;

   localparam int unsigned STAT_DISPLAY_BIT = 6;
   localparam int unsigned STAT_STANDBY_BIT = 0;

   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   typedef enum logic [3:0] {
      LCP_IDLE, LCP_SYS, LCP_REGION, LCP_SHAPE, LCP_GLYPH, LCP_HSHIFT, LCP_COMPOSE,
      LCP_DISP, LCP_CSR_WR, LCP_CSR_RD, LCP_MEM_WR, LCP_MEM_RD
   } lcp_state_t;
endpackage

/* File: verilog/lcp_sync.sv */
// three-stage input synchroniser, a bit changes once stages two and three agree
`timescale 1ns/1ns
module lcp_sync #(
   parameter int unsigned W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] stable_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge core_clk) begin
            if (rst) begin
               s1_q[i]     <= RESET_VAL[i];
               s2_q[i]     <= RESET_VAL[i];
               s3_q[i]     <= RESET_VAL[i];
               stable_q[i] <= RESET_VAL[i];
            end else begin
               s1_q[i] <= pin_in[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               // s1 stays private to s2, the filter only sees later stages
               if (s2_q[i] == s3_q[i]) begin
                  stable_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate
endmodule // lcp_sync

/* File: verilog/lcp_strobe.sv */
// turns synchronised bus pins into write and read events for either bus style
`timescale 1ns/1ns
module lcp_strobe (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       style,
   input  wire logic       cs_n,
   input  wire logic       rw_wr_n,
   input  wire logic       rd_n_e,
   input  wire logic       rs,
   input  wire logic [7:0] data,
   output logic            wr_ev,
   output logic            wr_rs,
   output logic [7:0]      wr_data,
   output logic            rd_start,
   output logic            rd_end
);
   logic       cs_n_q;
   logic       rw_wr_n_q;
   logic       rd_n_e_q;
   logic       rs_q;
   logic [7:0] data_q;
   logic       rd_act_q;

   wire sel       = ~cs_n;
   wire sel_prev  = ~cs_n_q;
   wire en_fall   = rd_n_e_q & ~rd_n_e;
   wire wr_rise   = ~rw_wr_n_q & rw_wr_n;
   wire wr_en_ev  = en_fall & sel_prev & ~rw_wr_n_q;
   wire wr_sep_ev = wr_rise & sel_prev;
   wire rd_en     = sel & rd_n_e & rw_wr_n;
   wire rd_sep    = sel & ~rd_n_e;
   wire rd_act    = style ? rd_en : rd_sep;

   // values one sample before the strobe edge, since hold time may be zero
   assign wr_ev    = style ? wr_en_ev : wr_sep_ev;
   assign wr_rs    = rs_q;
   assign wr_data  = data_q;
   assign rd_start = rd_act & ~rd_act_q;
   assign rd_end   = ~rd_act & rd_act_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_n_q    <= 1'b1;
         rw_wr_n_q <= 1'b1;
         rd_n_e_q  <= 1'b0;
         rs_q      <= 1'b0;
         data_q    <= lcp_pkg::BYTE_RESET;
         rd_act_q  <= 1'b0;
      end else begin
         cs_n_q    <= cs_n;
         rw_wr_n_q <= rw_wr_n;
         rd_n_e_q  <= rd_n_e;
         rs_q      <= rs;
         data_q    <= data;
         rd_act_q  <= rd_act;
      end
   end
endmodule // lcp_strobe

/* File: verif/lcp_command_port_properties.sv */
// pin-level assertion checker for the command port
`timescale 1ns/1ns
module lcp_command_port_props (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        dev_rst_n,
   input  wire logic        bus_style_select,
   input  wire logic        chip_sel_n,
   input  wire logic        wr_n_rw,
   input  wire logic        rd_n_en,
   input  wire logic        db_oe,
   input  wire logic [7:0]  fine_hshift_q,
   input  wire logic        display_on_q,
   input  wire logic [1:0]  cursor_dir_q,
   input  wire logic [15:0] cursor_addr_q,
   input  wire logic        standby_q,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_we,
   input  wire logic        mem_re
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_reset_clears_all:
      assert property (disable iff (1'b0) rst |=> !display_on_q && !standby_q && !db_oe
         && !mem_we && fine_hshift_q == 8'h00 && cursor_addr_q == 16'h0000)
      else $error("state not cleared by reset");
   a_devrst_quiet:
      assert property (!dev_rst_n [*6] |-> cursor_addr_q == 16'h0000 && !mem_we && !mem_re)
      else $error("activity while device reset held");
   a_we_single:
      assert property (mem_we |=> !mem_we) else $error("write pulse too long");
   a_re_single:
      assert property (mem_re |=> !mem_re) else $error("read pulse too long");
   a_we_moves_cursor:
      assert property (mem_we && !cursor_dir_q[1] |-> cursor_addr_q ==
         (cursor_dir_q == lcp_pkg::DIR_LEFT ? mem_addr - 16'h0001 : mem_addr + 16'h0001))
      else $error("cursor not stepped with write");
   a_oe_has_read:
      assert property ($rose(db_oe) |-> $past(!chip_sel_n &&
         (bus_style_select ? rd_n_en && wr_n_rw : !rd_n_en), 3))
      else $error("bus driven without a read");
   a_oe_released:
      assert property (chip_sel_n [*8] |-> !db_oe) else $error("bus held after deselect");
   a_quiet_bus_holds:
      assert property ((chip_sel_n && dev_rst_n) [*8] |=> $stable(fine_hshift_q)
         && $stable(display_on_q) && $stable(cursor_dir_q))
      else $error("settings changed with bus idle");
endmodule // lcp_command_port_props

bind lcp_command_port lcp_command_port_props u_props (.core_clk, .rst, .dev_rst_n,
   .bus_style_select, .chip_sel_n, .wr_n_rw, .rd_n_en, .db_oe, .fine_hshift_q, .display_on_q,
   .cursor_dir_q, .cursor_addr_q, .standby_q, .mem_addr, .mem_we, .mem_re);

/* File: verif/lcp_host_model.sv */
// host processor model driving the parallel port in either strobe style
`timescale 1ns/1ns
module lcp_host_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] db_out,
   input  wire logic       db_oe,
   output logic            bus_style_select,
   output logic            chip_sel_n,
   output logic            register_select,
   output logic            wr_n_rw,
   output logic            rd_n_en,
   output logic [7:0]      db_in
);
   // released lines show the inverse of the last value, never a stale copy
   task automatic idle(input logic rs, input logic [7:0] d);
      chip_sel_n = 1'b1;
      register_select = ~rs;
      db_in = ~d;
      wr_n_rw = 1'b1;
      rd_n_en = ~bus_style_select;
   endtask
   initial begin
      bus_style_select = 1'b0;
      idle(1'b0, 8'hff);
   end
   task automatic style(input logic s);
      @(negedge core_clk);
      bus_style_select = s;
      rd_n_en = ~s;
      repeat (8) @(negedge core_clk);
   endtask
   task automatic wr(input logic rs, input logic [7:0] d);
      @(negedge core_clk);
      chip_sel_n = 1'b0;
      register_select = rs;
      db_in = d;
      wr_n_rw = 1'b0;
      rd_n_en = 1'b1;
      repeat (4) @(negedge core_clk);
      if (bus_style_select) rd_n_en = 1'b0;
      else wr_n_rw = 1'b1;
      repeat (4) @(negedge core_clk);
      idle(rs, d);
      repeat (8) @(negedge core_clk);
   endtask
   task automatic rd(input logic rs, output logic [7:0] d, output logic oe);
      @(negedge core_clk);
      chip_sel_n = 1'b0;
      register_select = rs;
      rd_n_en = bus_style_select;
      repeat (8) @(negedge core_clk);
      d = db_out;
      oe = db_oe;
      rd_n_en = ~bus_style_select;
      repeat (2) @(negedge core_clk);
      idle(rs, d);
      repeat (8) @(negedge core_clk);
   endtask
endmodule // lcp_host_model

/* File: verif/tb.sv */
// self-checking bench for the command port
`timescale 1ns/1ns
module tb;
   typedef struct {
      logic [7:0]  c;
      logic        np;
      logic [7:0]  p;
      int          s;
      logic [15:0] e;
   } lcp_row_t;
   logic core_clk, rst, dev_rst_n, bus_style_select, chip_sel_n, register_select;
   logic wr_n_rw, rd_n_en, db_oe, display_on_q, standby_q, mem_we, mem_re, rd_oe;
   logic [7:0]       db_in, db_out, mem_wdata, fine_hshift_q, layer_compose_q;
   logic [7:0]       display_attr_q, rd_d;
   logic [7:0]       mem_rdata = 8'h00;
   logic [7:0][7:0]  sys_param_q;
   logic [9:0][7:0]  region_param_q;
   logic [1:0][7:0]  cursor_shape_q;
   logic [15:0]      glyph_base_q, cursor_addr_q, mem_addr;
   logic [1:0]       cursor_dir_q;
   logic [7:0]       mem [256];
   int               error_cnt = 0;
   int               total_checks = 0;
   int               we_cnt = 0;
   lcp_row_t rows [11] = '{
      '{8'h5a, 1, 8'h11, 0, 16'h11}, '{8'h5b, 1, 8'h5a, 1, 16'h5a},
      '{8'h58, 1, 8'h16, 2, 16'h16}, '{8'h58, 0, 8'h00, 3, 16'h0},
      '{8'h59, 0, 8'h00, 3, 16'h1}, '{8'h4d, 0, 8'h00, 4, 16'h1},
      '{8'h4e, 0, 8'h00, 4, 16'h2}, '{8'h4f, 0, 8'h00, 4, 16'h3},
      '{8'h4c, 0, 8'h00, 4, 16'h0}, '{8'h46, 1, 8'h34, 5, 16'h34},
      '{8'h53, 0, 8'h00, 6, 16'h1}};
   lcp_command_port dut (.core_clk, .rst, .dev_rst_n, .bus_style_select, .chip_sel_n,
      .register_select, .wr_n_rw, .rd_n_en, .db_in, .db_out, .db_oe, .sys_param_q,
      .region_param_q, .cursor_shape_q, .glyph_base_q, .fine_hshift_q, .layer_compose_q,
      .display_on_q, .display_attr_q, .cursor_dir_q, .cursor_addr_q, .standby_q, .mem_addr,
      .mem_wdata, .mem_we, .mem_re, .mem_rdata);
   lcp_host_model h (.core_clk, .db_out, .db_oe, .bus_style_select, .chip_sel_n,
      .register_select, .wr_n_rw, .rd_n_en, .db_in);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // read data only valid the cycle after the fetch pulse, garbled later
   always @(posedge core_clk) begin
      if (mem_we) begin
         mem[mem_addr[7:0]] <= mem_wdata;
         we_cnt <= we_cnt + 1;
      end
      mem_rdata <= mem_re ? mem[mem_addr[7:0]] : ~mem_rdata;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      h.wr(1'b1, c);
   endtask
   task automatic prm(input logic [7:0] p);
      h.wr(1'b0, p);
   endtask
   function automatic logic [15:0] obs(input int s);
      case (s)
         0: return {8'h00, fine_hshift_q};
         1: return {8'h00, layer_compose_q};
         2: return {8'h00, display_attr_q};
         3: return {15'h0, display_on_q};
         4: return {14'h0, cursor_dir_q};
         5: return cursor_addr_q;
         default: return {15'h0, standby_q};
      endcase
   endfunction
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge core_clk);
      error_cnt++;
      final_report;
   end
   initial begin
      rst = 1'b1;
      dev_rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      repeat (5) @(negedge core_clk);
      dev_rst_n = 1'b1;
      repeat (10) @(negedge core_clk);
      foreach (rows[i]) begin
         cmd(rows[i].c);
         if (rows[i].np) prm(rows[i].p);
         chk(obs(rows[i].s), rows[i].e);
      end
      cmd(8'h40);
      for (int i = 0; i < 7; i++) begin
         prm(8'h20 + 8'(i));
         chk(16'(sys_param_q[i]), 16'h20 + 16'(i));
      end
      cmd(8'h53);
      chk({sys_param_q[7], 7'h0, standby_q}, 16'h0001);
      cmd(8'h40);
      // nine bytes: the last one must be refused
      for (int i = 0; i < 9; i++) prm(8'h30 + 8'(i));
      chk({sys_param_q[7], sys_param_q[0]}, 16'h3730);
      chk(16'(standby_q), 16'h0);
      cmd(8'h44);
      prm(8'ha1);
      chk(16'(region_param_q[0]), 16'h0);
      prm(8'ha2);
      chk({region_param_q[1], region_param_q[0]}, 16'ha2a1);
      prm(8'ha3);
      chk(16'(region_param_q[2]), 16'ha3);
      prm(8'ha4);
      cmd(8'h4c);
      chk(16'(region_param_q[3]), 16'h0);
      cmd(8'h44);
      for (int i = 0; i < 10; i++) prm(8'hb0 + 8'(i));
      chk({region_param_q[9], region_param_q[3]}, 16'hb9b3);
      cmd(8'h5c);
      prm(8'h78);
      chk(glyph_base_q, 16'h0);
      prm(8'h56);
      chk(glyph_base_q, 16'h5678);
      cmd(8'h5c);
      prm(8'h9a);
      cmd(8'h5d);
      chk(glyph_base_q, 16'h5678);
      prm(8'h04);
      prm(8'h86);
      chk({cursor_shape_q[1], cursor_shape_q[0]}, 16'h8604);
      cmd(8'h46);
      prm(8'h10);
      prm(8'h00);
      cmd(8'h42);
      for (int i = 0; i < 3; i++) prm(8'hc0 + 8'(i));
      chk(cursor_addr_q, 16'h0013);
      chk({mem[8'h12], mem[8'h10]}, 16'hc2c0);
      chk(16'(we_cnt), 16'h3);
      cmd(8'h4d);
      cmd(8'h42);
      prm(8'hee);
      chk({mem[8'h13], cursor_addr_q[7:0]}, 16'hee12);
      cmd(8'h4c);
      cmd(8'h46);
      prm(8'h10);
      cmd(8'h43);
      for (int i = 0; i < 3; i++) begin
         h.rd(1'b1, rd_d, rd_oe);
         chk({rd_d, 7'h0, rd_oe}, {8'hc0 + 8'(i), 8'h01});
      end
      cmd(8'h46);
      prm(8'h34);
      prm(8'h12);
      cmd(8'h47);
      h.rd(1'b1, rd_d, rd_oe);
      chk(16'(rd_d), 16'h34);
      h.rd(1'b1, rd_d, rd_oe);
      chk(16'(rd_d), 16'h12);
      cmd(8'h4f); cmd(8'h42); prm(8'h5e);
      chk(cursor_addr_q, 16'h496a);
      cmd(8'h4e); cmd(8'h42); prm(8'h5f);
      chk(cursor_addr_q, 16'h1234);
      h.style(1'b1);
      cmd(8'h5a);
      prm(8'h77);
      chk(16'(fine_hshift_q), 16'h77);
      h.rd(1'b0, rd_d, rd_oe);
      chk({rd_d, 7'h0, rd_oe}, 16'h4001);
      h.style(1'b0);
      dev_rst_n = 1'b0;
      cmd(8'h5a);
      prm(8'h99);
      dev_rst_n = 1'b1;
      repeat (10) @(negedge core_clk);
      chk({fine_hshift_q, 7'h0, display_on_q}, 16'h0);
      cmd(8'h5a);
      prm(8'h55);
      rst = 1'b1;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      repeat (10) @(negedge core_clk);
      chk({fine_hshift_q, 7'h0, db_oe}, 16'h0);
      final_report;
   end
endmodule // tb
